//--- host_model.sv
`timescale 1ns/1ps
module host_model
  import mgmt_ctrl_pkg::*;
(
  input  wire logic hclk,
  output pins_t     pins
);
  // ----------------------------------------------------------------
  // Pin driving, always just after a rising edge
  // ----------------------------------------------------------------
  initial pins = PINS_IDLE;

  task automatic set_sel(input logic on);
    @(posedge hclk);
    pins.module_select_n <= ~on;
  endtask : set_sel

  task automatic set_lp(input logic on);
    @(posedge hclk);
    pins.low_power_request <= on;
  endtask : set_lp

  // Returns only once the synchroniser is empty again: a flag read
  // while the condition still stands would be set again at once
  task automatic cond_pulse(input logic [COND_W-1:0] c);
    @(posedge hclk);
    pins.cond <= c;
    repeat (6) @(posedge hclk);
    pins.cond <= 7'h00;
    repeat (3) @(posedge hclk);
  endtask : cond_pulse

  // Short pulses are only sent when a test asks for a glitch
  task automatic reset_pulse(input int cycles);
    @(posedge hclk);
    pins.module_reset_n <= 1'h0;
    repeat (cycles) @(posedge hclk);
    pins.module_reset_n <= 1'h1;
  endtask : reset_pulse
endmodule : host_model

//--- mgmt_ctrl.sv
// Local design decisions: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
// Functional notes
// RULE_01 - Fully functional within 2000 ms of start
// RULE_02 - Reset pin low over 2 us resets
// RULE_03 - Serial bus answers within 2000 ms
// RULE_04 - Not-ready cleared, interrupt asserted within 2000 ms
// RULE_05 - Functional within 2000 ms after reset release
// RULE_06 - Low-power pin enters low power within 100 us
// RULE_07 - Interrupt line low within 200 ms
// RULE_08 - Flag read clears; line high within 500 us
// RULE_09 - Receive loss flags within 100 ms
// RULE_10 - Transmit fault flags within 200 ms
// RULE_11 - Other conditions flag within 200 ms
// RULE_12 - Setting mask inhibits interrupt within 100 ms
// RULE_13 - Clearing mask resumes interrupt within 100 ms
// RULE_14 - Select asserted: answer bus within 100 us
// RULE_15 - Select released: stop answering within 100 us
// RULE_16 - Soft power-down enters low power within 100 ms
// RULE_17 - Power-down cleared: functional within 300 ms
// RULE_18 - Write timings start after write completes
// RULE_19 - Interrupt is OR of unmasked set flags
module mgmt_ctrl
  import mgmt_ctrl_pkg::*;
#(
  parameter int INIT_SETTLE = INIT_SETTLE_CYC,
  parameter int INIT_LIMIT  = T_INIT_CYC,
  parameter int LP_LIMIT    = T_LP_CYC,
  parameter int SEL_LIMIT   = T_SELECT_CYC,
  parameter int MASK_LIMIT  = T_MASK_CYC
)(
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire logic              module_reset_n,
  input  wire logic              low_power_request,
  input  wire logic              module_select_n,
  input  wire logic [COND_W-1:0] condition_in,
  output logic                   interrupt_request_n,
  output logic                   serial_enable,
  output logic                   low_power_state,
  output logic                   data_not_ready,
  output logic                   irq
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (INIT_SETTLE < 2 || INIT_SETTLE + PATH_LATENCY_CYC > INIT_LIMIT)
    $error("INIT_SETTLE out of range");
  if (PATH_LATENCY_CYC > LP_LIMIT || PATH_LATENCY_CYC > SEL_LIMIT)
    $error("Pin path too slow");
  if (PATH_LATENCY_CYC > MASK_LIMIT || PATH_LATENCY_CYC > T_INT_CLEAR_CYC)
    $error("Register path too slow");
  if (T_RESET_PULSE_CYC >= 4096)
    $error("Reset filter counter too narrow");

  localparam logic [11:0] RST_CYC = 12'(T_RESET_PULSE_CYC);
  localparam logic [31:0] SETTLE_LAST = 32'(INIT_SETTLE - 1);

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  pins_t pins_raw;
  pins_t sync1_r;
  pins_t sync2_r;

  assign pins_raw = '{module_reset_n, low_power_request,
                      module_select_n, condition_in};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_r <= PINS_IDLE;
      sync2_r <= PINS_IDLE;
    end
    else
    begin
      sync1_r <= pins_raw;
      sync2_r <= sync1_r;
    end
  end

  // ----------------------------------------------------------------
  // Reset pin pulse filter
  // ----------------------------------------------------------------
  logic [11:0] rst_cnt_r;
  logic        in_reset_r;

  // Glitches shorter than the minimum pulse never reach the logic
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      rst_cnt_r <= 12'h000;
    else if (sync2_r.module_reset_n)
      rst_cnt_r <= 12'h000;
    else if (rst_cnt_r != RST_CYC)
      rst_cnt_r <= rst_cnt_r + 12'h001;

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      in_reset_r <= 1'b0;
    else if (sync2_r.module_reset_n)
      in_reset_r <= 1'b0;
    else if (rst_cnt_r == RST_CYC)
      in_reset_r <= 1'b1; // RULE_02

  // ----------------------------------------------------------------
  // Initialisation
  // ----------------------------------------------------------------
  logic [31:0] init_cnt_r;
  logic        data_not_ready_r;
  logic        init_done_w;

  assign init_done_w = data_not_ready_r && !in_reset_r
                       && init_cnt_r == SETTLE_LAST;

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      init_cnt_r <= 32'h0;
    else if (in_reset_r || !data_not_ready_r)
      init_cnt_r <= 32'h0;
    else
      init_cnt_r <= init_cnt_r + 32'h1;

  // Restart from power-up or from the end of a pin reset
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      data_not_ready_r <= 1'b1;
    else if (in_reset_r)
      data_not_ready_r <= 1'b1;
    else if (init_done_w)
      data_not_ready_r <= 1'b0; // RULE_01 RULE_04 RULE_05

  assign data_not_ready = data_not_ready_r;

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  logic    addr_phase_w;
  logic    rd_flags_w;
  ahb_wr_t wr_r;
  logic    wr_mask_w;
  logic    wr_ctrl_w;
  logic    wr_irq_clr_w;
  logic    wr_irq_en_w;

  logic [FLAG_W-1:0] flags_r;
  logic [FLAG_W-1:0] mask_r;
  logic              pdown_r;
  logic              serial_enable_r;
  logic              low_power_r;
  logic [IRQ_W-1:0]  irq_status_r;
  logic [IRQ_W-1:0]  irq_enable_r;
  logic [31:0]       hrdata_r;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // Zero wait states; every transfer completes OKAY
  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  assign addr_phase_w = hsel && htrans[1] && hready;
  assign rd_flags_w   = addr_phase_w && !hwrite
                        && hit(haddr[7:0], ADDR_FLAGS)
                        && haddr[31:8] == 24'h0;

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      wr_r <= '0;
    else if (hready)
      wr_r <= '{addr_phase_w && hwrite && haddr[31:8] == 24'h0,
                haddr[7:0]};

  // Write data lands in the data phase; effects start next edge
  assign wr_mask_w    = wr_r.valid && hit(wr_r.addr, ADDR_MASK);
  assign wr_ctrl_w    = wr_r.valid && hit(wr_r.addr, ADDR_CONTROL);
  assign wr_irq_clr_w = wr_r.valid && hit(wr_r.addr, ADDR_IRQ_CLEAR);
  assign wr_irq_en_w  = wr_r.valid && hit(wr_r.addr, ADDR_IRQ_ENABLE);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_r <= 32'h0;
    else if (addr_phase_w && !hwrite)
    begin
      hrdata_r <= 32'h0;
      if (haddr[31:8] == 24'h0)
        unique case (haddr[7:0])
          ADDR_STATUS:     hrdata_r <= {28'h0, in_reset_r, low_power_r,
                                        serial_enable_r, data_not_ready_r};
          ADDR_FLAGS:      hrdata_r <= {24'h0, flags_r};
          ADDR_MASK:       hrdata_r <= {24'h0, mask_r};
          ADDR_CONTROL:    hrdata_r <= {31'h0, pdown_r};
          ADDR_IRQ_STATUS: hrdata_r <= {29'h0, irq_status_r};
          ADDR_IRQ_ENABLE: hrdata_r <= {29'h0, irq_enable_r};
          default:         hrdata_r <= 32'h0;
        endcase
    end
  end

  assign hrdata = hrdata_r;

  // ----------------------------------------------------------------
  // Flags, mask and interrupt line
  // ----------------------------------------------------------------
  logic [FLAG_W-1:0] flag_set_w;
  logic              int_n_r;

  assign flag_set_w = {init_done_w, sync2_r.cond};

  // Set wins over the clear of a read in the same cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      flags_r <= '0;
    else if (in_reset_r)
      flags_r <= '0;
    else if (rd_flags_w)
      flags_r <= flag_set_w; // RULE_08
    else
      flags_r <= flags_r | flag_set_w; // RULE_09 RULE_10 RULE_11
  end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      mask_r <= MASK_RESET;
    else if (in_reset_r)
      mask_r <= MASK_RESET;
    else if (wr_mask_w)
      mask_r <= hwdata[FLAG_W-1:0]; // RULE_12 RULE_13 RULE_18

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      int_n_r <= 1'b1;
    else
      int_n_r <= ~(|(flags_r & ~mask_r)); // RULE_07 RULE_19

  assign interrupt_request_n = int_n_r;

  // ----------------------------------------------------------------
  // Select gating and power level
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      serial_enable_r <= 1'b0;
    else
      serial_enable_r <= !sync2_r.module_select_n // RULE_14 RULE_15
                         && !data_not_ready_r && !in_reset_r; // RULE_03

  assign serial_enable = serial_enable_r;

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      pdown_r <= 1'b0;
    else if (in_reset_r)
      pdown_r <= 1'b0;
    else if (wr_ctrl_w)
      pdown_r <= hwdata[CTRL_PDOWN]; // RULE_18

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      low_power_r <= 1'b0;
    else
      low_power_r <= sync2_r.low_power_request // RULE_06
                     || pdown_r; // RULE_16 RULE_17

  assign low_power_state = low_power_r;

  // ----------------------------------------------------------------
  // Software interrupt
  // ----------------------------------------------------------------
  logic [IRQ_W-1:0] irq_event_w;
  logic             in_reset_d_r;

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      in_reset_d_r <= 1'b0;
    else
      in_reset_d_r <= in_reset_r;

  always_comb
  begin
    irq_event_w            = '0;
    irq_event_w[IRQ_FLAG]  = |(flag_set_w & ~flags_r) && !in_reset_r;
    irq_event_w[IRQ_INIT]  = init_done_w;
    irq_event_w[IRQ_RESET] = in_reset_r && !in_reset_d_r;
  end

  // Clear is write-one; a simultaneous event keeps its bit
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_status_r <= IRQ_RESET_V;
    else if (wr_irq_clr_w)
      irq_status_r <= (irq_status_r & ~hwdata[IRQ_W-1:0]) | irq_event_w;
    else
      irq_status_r <= irq_status_r | irq_event_w;
  end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      irq_enable_r <= IRQ_RESET_V;
    else if (wr_irq_en_w)
      irq_enable_r <= hwdata[IRQ_W-1:0];

  assign irq = |(irq_status_r & irq_enable_r);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_flag_read_quiet;
    rd_flags_w && flag_set_w == '0;
  endsequence
  sequence s_init_finish;
    $fell(data_not_ready_r) && !mask_r[FLAG_INIT];
  endsequence
  // Synchronised pin is still low when the filter fires
  property p_reset_filter;
    $rose(in_reset_r) |-> $past(rst_cnt_r) == RST_CYC
                          && !$past(sync2_r.module_reset_n);
  endproperty
  a_reset_filter: assert property (p_reset_filter) // RULE_02
    else $error("Reset taken before minimum pulse");
  property p_init_done;
    s_init_finish |-> flags_r[FLAG_INIT] ##1 !interrupt_request_n;
  endproperty
  a_init_done: assert property (p_init_done) // RULE_04
    else $error("Init end did not raise interrupt");
  property p_select_on;
    !sync2_r.module_select_n && !data_not_ready_r && !in_reset_r
      |=> serial_enable;
  endproperty
  a_select_on: assert property (p_select_on) // RULE_14
    else $error("Select did not enable bus");
  property p_select_off;
    sync2_r.module_select_n |=> !serial_enable;
  endproperty
  a_select_off: assert property (p_select_off) // RULE_15
    else $error("Deselect did not stop bus");
  property p_low_power_pin;
    sync2_r.low_power_request |=> low_power_state;
  endproperty
  a_low_power_pin: assert property (p_low_power_pin) // RULE_06
    else $error("Low-power pin ignored");
  property p_pdown_on;
    pdown_r |=> low_power_state;
  endproperty
  a_pdown_on: assert property (p_pdown_on) // RULE_16
    else $error("Power-down bit ignored");
  property p_pdown_off;
    !pdown_r && !sync2_r.low_power_request |=> !low_power_state;
  endproperty
  a_pdown_off: assert property (p_pdown_off) // RULE_17
    else $error("Power level not restored");
  // A mask written one cycle later legally keeps the line high
  property p_rx_loss;
    sync2_r.cond[FLAG_RX_LOSS] && !in_reset_r && !mask_r[FLAG_RX_LOSS]
      |=> flags_r[FLAG_RX_LOSS]
          ##1 (!interrupt_request_n || $past(mask_r[FLAG_RX_LOSS]));
  endproperty
  a_rx_loss: assert property (p_rx_loss) // RULE_09
    else $error("Receive loss not flagged");
  property p_tx_fault;
    sync2_r.cond[FLAG_TX_FAULT] && !in_reset_r
      |=> flags_r[FLAG_TX_FAULT];
  endproperty
  a_tx_fault: assert property (p_tx_fault) // RULE_10
    else $error("Transmit fault not flagged");
  property p_int_level;
    |(flags_r & ~mask_r) |=> !interrupt_request_n;
  endproperty
  a_int_level: assert property (p_int_level) // RULE_19
    else $error("Unmasked flag without interrupt");
  property p_mask_all;
    (flags_r & ~mask_r) == '0 |=> interrupt_request_n;
  endproperty
  a_mask_all: assert property (p_mask_all) // RULE_12
    else $error("Masked flags still interrupt");
  property p_clear_read;
    s_flag_read_quiet |=> flags_r == '0 ##1 interrupt_request_n;
  endproperty
  a_clear_read: assert property (p_clear_read) // RULE_08
    else $error("Flag read did not release line");
endmodule : mgmt_ctrl

//--- mgmt_ctrl_pkg.sv
package mgmt_ctrl_pkg;

  // ----------------------------------------------------------------
  // Clock and timing limits
  // ----------------------------------------------------------------
  localparam int CLK_KHZ          = 100000;
  localparam int T_INIT_MS        = 2000;
  localparam int T_RESET_PULSE_US = 2;
  localparam int T_LP_US          = 100;
  localparam int T_INT_ASSERT_MS  = 200;
  localparam int T_INT_CLEAR_US   = 500;
  localparam int T_MASK_MS        = 100;
  localparam int T_SELECT_US      = 100;
  localparam int T_PDOWN_MS       = 100;
  localparam int T_PUP_MS         = 300;

  // Least time: round up
  localparam int T_RESET_PULSE_CYC = (T_RESET_PULSE_US * CLK_KHZ + 999) / 1000;
  // Longest times: round down
  localparam int T_INIT_CYC       = T_INIT_MS * CLK_KHZ;
  localparam int T_LP_CYC         = (T_LP_US * CLK_KHZ) / 1000;
  localparam int T_INT_ASSERT_CYC = T_INT_ASSERT_MS * CLK_KHZ;
  localparam int T_INT_CLEAR_CYC  = (T_INT_CLEAR_US * CLK_KHZ) / 1000;
  localparam int T_MASK_CYC       = T_MASK_MS * CLK_KHZ;
  localparam int T_SELECT_CYC     = (T_SELECT_US * CLK_KHZ) / 1000;
  localparam int T_PDOWN_CYC      = T_PDOWN_MS * CLK_KHZ;
  localparam int T_PUP_CYC        = T_PUP_MS * CLK_KHZ;

  // Worst path from pin to output, synchroniser included
  localparam int PATH_LATENCY_CYC = 4;
  localparam int INIT_SETTLE_CYC  = 64;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS     = 8'h00;
  localparam logic [7:0] ADDR_FLAGS      = 8'h04;
  localparam logic [7:0] ADDR_MASK       = 8'h08;
  localparam logic [7:0] ADDR_CONTROL    = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h14;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h18;

  localparam int FLAG_W        = 8;
  localparam int COND_W        = 7;
  localparam int FLAG_RX_LOSS  = 0;
  localparam int FLAG_TX_FAULT = 1;
  localparam int FLAG_INIT     = 7;

  localparam int ST_NOT_READY  = 0;
  localparam int ST_SERIAL_EN  = 1;
  localparam int ST_LOW_POWER  = 2;
  localparam int ST_IN_RESET   = 3;

  localparam int CTRL_PDOWN    = 0;

  localparam int IRQ_W         = 3;
  localparam int IRQ_FLAG      = 0;
  localparam int IRQ_INIT      = 1;
  localparam int IRQ_RESET     = 2;

  localparam logic [FLAG_W-1:0] MASK_RESET  = 8'h00;
  localparam logic [IRQ_W-1:0]  IRQ_RESET_V = 3'h0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              module_reset_n;
    logic              low_power_request;
    logic              module_select_n;
    logic [COND_W-1:0] cond;
  } pins_t;

  localparam pins_t PINS_IDLE = '{1'b1, 1'b0, 1'b1, 7'h00};

  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
  } ahb_wr_t;

endpackage : mgmt_ctrl_pkg

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
  import mgmt_ctrl_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        irq_n;
  logic        ser_en;
  logic        lp_state;
  logic        dnr;
  logic        irq;
  pins_t       pins;
  logic        rd_chk  = 1'h0;
  logic [31:0] exp_q[$];
  logic [6:0]  rnd;
  int          mismatches = 0;
  int          n_tests    = 0;
  wire  [4:0]  outs = {irq, dnr, lp_state, ser_en, irq_n};
  localparam int O_INTN = 0, O_SEL = 1, O_LP = 2, O_DNR = 3, O_IRQ = 4;

  // Unknown at time zero counts as low
  always #5 hclk = (hclk !== 1'h1);

  mgmt_ctrl #(.INIT_SETTLE(4)) i_dut (
    .hclk                (hclk),
    .hresetn             (hresetn),
    .hsel                (hsel),
    .haddr               (haddr),
    .htrans              (htrans),
    .hwrite              (hwrite),
    .hsize               (hsize),
    .hwdata              (hwdata),
    .hready              (hreadyout),
    .hreadyout           (hreadyout),
    .hresp               (hresp),
    .hrdata              (hrdata),
    .module_reset_n      (pins.module_reset_n),
    .low_power_request   (pins.low_power_request),
    .module_select_n     (pins.module_select_n),
    .condition_in        (pins.cond),
    .interrupt_request_n (irq_n),
    .serial_enable       (ser_en),
    .low_power_state     (lp_state),
    .data_not_ready      (dnr),
    .irq                 (irq)
  );

  host_model i_host (
    .hclk (hclk),
    .pins (pins)
  );

  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic fail(input string msg);
    mismatches++;
    $display("[ERR] %0t %s", $time, msg);
  endtask : fail

  task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
      fail($sformatf("read %h, expected %h", got, exp));
  endtask : cmp_rd

  task automatic cmp_resp(input logic got);
    n_tests++;
    if (got !== 1'h0)
      fail("error response on read");
  endtask : cmp_resp

  // Read data is taken at the edge that ends the data phase
  always @(posedge hclk)
    if (rd_chk && hreadyout === 1'h1)
    begin
      cmp_rd(hrdata, exp_q.pop_front());
      cmp_resp(hresp);
    end

  // Bounded wait on one output; lim 0 means it must hold now
  task automatic wait_out(input int idx, input logic v, input int lim);
    int k;
    k = 0;
    #1;
    while (outs[idx] !== v && k < lim)
    begin
      @(posedge hclk);
      #1;
      k++;
    end
    n_tests++;
    if (outs[idx] !== v)
      fail($sformatf("output %0d did not reach %b", idx, v));
  endtask : wait_out

  // ----------------------------------------------------------------
  // Bus master: single word transfers, reads note their expectation
  // ----------------------------------------------------------------
  task automatic ahb(input logic [7:0] a, input logic wr,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'h1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    if (!wr)
    begin
      exp_q.push_back(d);
      rd_chk <= 1'h1;
    end
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd_chk <= 1'h0;
  endtask : ahb

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    hresetn <= 1'h0;
    hsel    <= 1'h0;
    haddr   <= 32'h0;
    htrans  <= 2'h0;
    hwrite  <= 1'h0;
    hsize   <= 3'h2;
    hwdata  <= 32'h0;
    void'($urandom(58));
    repeat (5) @(posedge hclk);
    hresetn <= 1'h1;
    wait_out(O_DNR, 1'h0, 20);
    wait_out(O_INTN, 1'h0, 4);
    ahb(ADDR_STATUS, 1'h0, 32'h0);
    ahb(ADDR_MASK, 1'h0, 32'h0);
    ahb(ADDR_CONTROL, 1'h0, 32'h0);
    ahb(ADDR_IRQ_ENABLE, 1'h0, 32'h0);
    ahb(ADDR_FLAGS, 1'h0, 32'h80);
    wait_out(O_INTN, 1'h1, 8);
    ahb(ADDR_IRQ_CLEAR, 1'h1, 32'h7);
    ahb(ADDR_IRQ_STATUS, 1'h0, 32'h0);
    ahb(ADDR_IRQ_ENABLE, 1'h1, 32'h1);
    // Every condition alone, then random mixes
    for (int i = 0; i < 11; i++)
    begin
      rnd = (i < 7) ? 7'(1 << i) : 7'($urandom_range(127, 1));
      i_host.cond_pulse(rnd);
      wait_out(O_INTN, 1'h0, 8);
      wait_out(O_IRQ, 1'h1, 2);
      ahb(ADDR_FLAGS, 1'h0, {25'h0, rnd});
      wait_out(O_INTN, 1'h1, 8);
      ahb(ADDR_IRQ_CLEAR, 1'h1, 32'h1);
      wait_out(O_IRQ, 1'h0, 2);
    end
    // Mask inhibits, and a flag left set fires once unmasked
    ahb(ADDR_MASK, 1'h1, 32'h01);
    ahb(ADDR_MASK, 1'h0, 32'h01);
    i_host.cond_pulse(7'h01);
    repeat (8) @(posedge hclk);
    wait_out(O_INTN, 1'h1, 0);
    ahb(ADDR_MASK, 1'h1, 32'h00);
    wait_out(O_INTN, 1'h0, 4);
    ahb(ADDR_FLAGS, 1'h0, 32'h01);
    wait_out(O_INTN, 1'h1, 8);
    // Disabled event still latches its status bit
    ahb(ADDR_IRQ_CLEAR, 1'h1, 32'h7);
    ahb(ADDR_IRQ_ENABLE, 1'h1, 32'h0);
    i_host.cond_pulse(7'h02);
    wait_out(O_INTN, 1'h0, 8);
    wait_out(O_IRQ, 1'h0, 0);
    ahb(ADDR_IRQ_STATUS, 1'h0, 32'h1);
    ahb(ADDR_IRQ_ENABLE, 1'h0, 32'h0);
    ahb(ADDR_FLAGS, 1'h0, 32'h02);
    ahb(ADDR_IRQ_CLEAR, 1'h1, 32'h7);
    ahb(ADDR_IRQ_STATUS, 1'h0, 32'h0);
    // Unmapped place: write ignored, read zero
    ahb(8'h20, 1'h1, 32'hffff_ffff);
    ahb(8'h20, 1'h0, 32'h0);
    // Select pin
    i_host.set_sel(1'h1);
    wait_out(O_SEL, 1'h1, 5);
    ahb(ADDR_STATUS, 1'h0, 32'h2);
    i_host.set_sel(1'h0);
    wait_out(O_SEL, 1'h0, 5);
    // Low power from the pin and from software
    i_host.set_lp(1'h1);
    wait_out(O_LP, 1'h1, 5);
    ahb(ADDR_STATUS, 1'h0, 32'h4);
    i_host.set_lp(1'h0);
    wait_out(O_LP, 1'h0, 5);
    ahb(ADDR_CONTROL, 1'h1, 32'h1);
    wait_out(O_LP, 1'h1, 4);
    ahb(ADDR_CONTROL, 1'h0, 32'h1);
    ahb(ADDR_CONTROL, 1'h1, 32'h0);
    wait_out(O_LP, 1'h0, 4);
    // Module reset pin: a glitch is ignored, a long pulse is not
    ahb(ADDR_MASK, 1'h1, 32'h04);
    i_host.reset_pulse(100);
    repeat (10) @(posedge hclk);
    wait_out(O_DNR, 1'h0, 0);
    fork
      i_host.reset_pulse(300);
      begin
        repeat (260) @(posedge hclk);
        wait_out(O_DNR, 1'h1, 0);
        ahb(ADDR_STATUS, 1'h0, 32'h9);
      end
    join
    wait_out(O_DNR, 1'h0, 16);
    wait_out(O_INTN, 1'h0, 4);
    ahb(ADDR_MASK, 1'h0, 32'h0);
    ahb(ADDR_FLAGS, 1'h0, 32'h80);
    wait_out(O_INTN, 1'h1, 8);
    repeat (4) @(posedge hclk);
    report_and_stop();
  end

  // Whole sequence needs well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge hclk);
    fail("watchdog expired");
    report_and_stop();
  end
endmodule : testbench
